// ==== rtl/scr_consts.svh ====
// Purpose: timing counts and field figures for the converter control block
// Assumes: clk_in at 200 MHz (5 ns period)
// Notes: times kept in their printed units, cycle counts derived from them
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH
`define SCR_CLK_PERIOD_PS 5000
`define SCR_WORD_BITS 16
`define SCR_CONV_TIME_NS 7600
`define SCR_CONV_CYCLES ((`SCR_CONV_TIME_NS * 1000) / `SCR_CLK_PERIOD_PS)
`define SCR_FIRST_CLK_NS 450
`define SCR_FIRST_CLK_CYCLES ((`SCR_FIRST_CLK_NS * 1000) / `SCR_CLK_PERIOD_PS)
`define SCR_BIT_PERIOD_NS 440
`define SCR_HALF_BIT_CYCLES (((`SCR_BIT_PERIOD_NS * 1000) / `SCR_CLK_PERIOD_PS) / 2)
`define SCR_SB_FLIP_MASK 16'h8000
`endif

// ==== rtl/scr_pkg.sv ====
// Purpose: types shared by the converter control block
// Assumes: nothing
// Notes: states are binary coded
package scr_pkg;
    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_WAIT = 2'b01,
        SCR_SHIFT = 2'b10
    } scr_tx_state_t;
endpackage

// ==== rtl/scr_core.sv ====
// Purpose: conversion control and serial readout of a 16-bit sampling converter
// Assumes: link bit clock from host is an unrelated domain in external mode
// Notes: analog conversion modelled by a counter and a sample input word
`timescale 1ns/100ps
`include "scr_consts.svh"

// Behaviour
// (R1) cs low, read-convert fall starts conversion
// (R2) internal mode: start edge begins result shift
// (R3) external mode: sync then previous result sent
// (R4) cs and read-convert combined by logical or
// (R5) busy low from start until result loaded
// (R6) host keeps cs or read-convert high at busy rise
// (R7) power-down refuses conversions, reduces power
// (R8) power-down keeps last result in shifter
// (R9) first internal bit clock about 450 ns later
// (R10) format high straight binary, low two's complement
// (R11) internal mode: exactly 16 pulses, then low
// (R12) external mode: tag relayed after 16 bits
// (R13) msb first, one bit per clock
module scr_core
    import scr_pkg::*;
#(
    parameter int WORD_BITS = `SCR_WORD_BITS,
    parameter int CONV_CYCLES = `SCR_CONV_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic chip_select_n_in,
    input wire logic read_convert_in,
    input wire logic power_down_in,
    input wire logic clock_source_select_in,
    input wire logic output_format_select_in,
    input wire logic tag_in,
    input wire logic [WORD_BITS-1:0] sample_in,
    output logic busy_n_out,
    output logic power_reduced_out,
    output logic serial_bit_clock_out,
    output logic serial_bit_clock_oe_out,
    output logic serial_data_out,
    output logic sync_out,
    output logic result_valid_out,
    input wire logic result_ready_in,
    output logic [WORD_BITS-1:0] result_data_out
);
    localparam int CW = 16;

    // =========================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [2:0] cs_sync_ff;
    logic [2:0] rc_sync_ff;
    logic [2:0] pd_sync_ff;
    logic [2:0] ext_sync_ff;
    logic [2:0] fmt_sync_ff;
    logic cs_ff;
    logic rc_ff;
    logic pd_ff;
    logic ext_ff;
    logic fmt_ff;
    logic trig_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_sync_ff <= 3'h7;
            rc_sync_ff <= 3'h7;
            pd_sync_ff <= 3'h0;
            ext_sync_ff <= 3'h0;
            fmt_sync_ff <= 3'h0;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], chip_select_n_in};
            rc_sync_ff <= {rc_sync_ff[1:0], read_convert_in};
            pd_sync_ff <= {pd_sync_ff[1:0], power_down_in};
            ext_sync_ff <= {ext_sync_ff[1:0], clock_source_select_in};
            fmt_sync_ff <= {fmt_sync_ff[1:0], output_format_select_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_ff <= 1'b1;
            rc_ff <= 1'b1;
            pd_ff <= 1'b0;
            ext_ff <= 1'b0;
            fmt_ff <= 1'b0;
        end else begin
            if (cs_sync_ff[1] == cs_sync_ff[2]) cs_ff <= cs_sync_ff[2];
            if (rc_sync_ff[1] == rc_sync_ff[2]) rc_ff <= rc_sync_ff[2];
            if (pd_sync_ff[1] == pd_sync_ff[2]) pd_ff <= pd_sync_ff[2];
            if (ext_sync_ff[1] == ext_sync_ff[2]) ext_ff <= ext_sync_ff[2];
            if (fmt_sync_ff[1] == fmt_sync_ff[2]) fmt_ff <= fmt_sync_ff[2];
        end
    end

    // =========================================================
    // trigger: or of both active-low inputs, its fall starts a conversion
    logic trig_level;
    logic start_conv;
    logic conv_go;
    logic conv_busy_ff;
    logic [CW-1:0] conv_cnt_ff;
    logic [WORD_BITS-1:0] result_ff;
    logic load_done;

    assign trig_level = cs_ff | rc_ff; // R4
    // a trigger still low when busy rises restarts at once, as the host is warned
    assign start_conv = !trig_level && (trig_ff || load_done) && !pd_ff; // R1 R6 R7
    // only a free converter, or one finishing this cycle, accepts the start
    assign conv_go = start_conv && (!conv_busy_ff || load_done);

    always_ff @(posedge clk_in) begin
        if (rst_in) trig_ff <= 1'b1;
        else trig_ff <= trig_level;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            conv_busy_ff <= 1'b0;
            conv_cnt_ff <= 16'h0000;
        end else if (conv_go) begin
            conv_busy_ff <= 1'b1; // R5
            conv_cnt_ff <= CW'(CONV_CYCLES - 1);
        end else if (conv_busy_ff) begin
            if (conv_cnt_ff == 16'h0000) conv_busy_ff <= 1'b0;
            else conv_cnt_ff <= conv_cnt_ff - 16'h0001;
        end
    end

    assign load_done = conv_busy_ff && (conv_cnt_ff == 16'h0000);
    assign busy_n_out = !conv_busy_ff; // R5
    assign power_reduced_out = pd_ff; // R7

    // result latched at end of conversion, held through power-down
    always_ff @(posedge clk_in) begin
        if (rst_in) result_ff <= 16'h0000;
        else if (load_done) // R8
            result_ff <= fmt_ff ? (sample_in ^ `SCR_SB_FLIP_MASK) : sample_in; // R10
    end

    // =========================================================
    // two-entry buffer of finished words toward the parallel reader
    logic [WORD_BITS-1:0] buf_ff [2];
    logic [1:0] buf_cnt_ff;
    logic buf_rd_ff;
    logic buf_push;
    logic buf_pop;

    assign buf_push = load_done && (buf_cnt_ff != 2'h2);
    assign buf_pop = result_valid_out && result_ready_in;
    assign result_valid_out = (buf_cnt_ff != 2'h0);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            buf_cnt_ff <= 2'h0;
            buf_rd_ff <= 1'b0;
        end else begin
            buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
            if (buf_pop) buf_rd_ff <= !buf_rd_ff;
        end
    end

    always_ff @(posedge clk_in) begin
        if (buf_push) buf_ff[buf_rd_ff ^ buf_cnt_ff[0]] <= result_ff_next();
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) result_data_out <= 16'h0000;
        else if (buf_cnt_ff == 2'h0 && buf_push) result_data_out <= result_ff_next();
        // a pop and a push together hand the new word straight to the head
        else if (buf_pop && buf_push && buf_cnt_ff == 2'h1) result_data_out <= result_ff_next();
        else if (buf_pop && buf_cnt_ff == 2'h2) result_data_out <= buf_ff[!buf_rd_ff];
    end

    function automatic logic [WORD_BITS-1:0] result_ff_next();
        result_ff_next = fmt_ff ? (sample_in ^ `SCR_SB_FLIP_MASK) : sample_in;
    endfunction

    // =========================================================
    // internal-clock serialiser on clk_in
    scr_tx_state_t int_state_ff;
    logic [CW-1:0] int_tmr_ff;
    logic [4:0] int_bits_ff;
    logic [WORD_BITS-1:0] int_shift_ff;
    logic int_clk_ff;
    logic int_data_ff;
    logic [WORD_BITS-1:0] int_src;

    // a restart at busy rise sends the word being latched in that same cycle
    assign int_src = load_done ? result_ff_next() : result_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            int_state_ff <= SCR_IDLE;
            int_tmr_ff <= 16'h0000;
            int_bits_ff <= 5'h00;
            int_shift_ff <= 16'h0000;
            int_clk_ff <= 1'b0;
            int_data_ff <= 1'b0;
        end else begin
            case (int_state_ff)
                SCR_IDLE: begin
                    int_clk_ff <= 1'b0; // R11
                    if (conv_go && !ext_ff) begin
                        int_shift_ff <= int_src; // R2
                        int_data_ff <= int_src[WORD_BITS-1];
                        int_tmr_ff <= CW'(`SCR_FIRST_CLK_CYCLES - 1); // R9
                        int_bits_ff <= 5'h00;
                        int_state_ff <= SCR_WAIT;
                    end else begin
                        int_data_ff <= tag_in;
                    end
                end
                SCR_WAIT: begin
                    if (int_tmr_ff == 16'h0000) begin
                        int_clk_ff <= 1'b1;
                        int_tmr_ff <= CW'(`SCR_HALF_BIT_CYCLES - 1);
                        int_state_ff <= SCR_SHIFT;
                    end else begin
                        int_tmr_ff <= int_tmr_ff - 16'h0001;
                    end
                end
                SCR_SHIFT: begin
                    if (int_tmr_ff != 16'h0000) begin
                        int_tmr_ff <= int_tmr_ff - 16'h0001;
                    end else if (int_clk_ff) begin
                        int_clk_ff <= 1'b0;
                        int_tmr_ff <= CW'(`SCR_HALF_BIT_CYCLES - 1);
                        int_bits_ff <= int_bits_ff + 5'h01;
                        int_shift_ff <= {int_shift_ff[WORD_BITS-2:0], 1'b0}; // R13
                        int_data_ff <= int_shift_ff[WORD_BITS-2];
                        if (int_bits_ff == 5'(WORD_BITS - 1)) int_state_ff <= SCR_IDLE; // R11
                    end else begin
                        int_clk_ff <= 1'b1;
                        int_tmr_ff <= CW'(`SCR_HALF_BIT_CYCLES - 1);
                    end
                end
                default: int_state_ff <= SCR_IDLE;
            endcase
        end
    end

    // =========================================================
    // external-clock readout: request toggles across to the link domain
    logic ext_req_tgl_ff;
    logic [WORD_BITS-1:0] ext_word_ff;
    logic ext_req_edge;
    logic cs_prev_ff;
    logic rc_prev_ff;

    // the or of the two pins cannot see a cs fall under a high read-convert,
    // so each pin keeps its own previous level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cs_prev_ff <= 1'b1;
            rc_prev_ff <= 1'b1;
        end else begin
            cs_prev_ff <= cs_ff;
            rc_prev_ff <= rc_ff;
        end
    end

    // rising read-convert with cs low, or falling cs with read-convert high
    assign ext_req_edge = ext_ff && !cs_ff && rc_ff && (!rc_prev_ff || cs_prev_ff); // R3

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_req_tgl_ff <= 1'b0;
            ext_word_ff <= 16'h0000;
        end else if (ext_req_edge) begin
            ext_req_tgl_ff <= !ext_req_tgl_ff; // R3
            ext_word_ff <= result_ff;
        end
    end

    // link domain: the word is stable for many link clocks before the toggle lands
    logic [2:0] lk_tgl_ff;
    logic lk_seen_ff;
    logic lk_sync_ff;
    logic lk_active_ff;
    logic [WORD_BITS-1:0] lk_shift_ff;
    logic lk_data_ff;

    always_ff @(posedge link_clk_in) begin
        lk_tgl_ff <= {lk_tgl_ff[1:0], ext_req_tgl_ff};
        // the seen level follows every agreed toggle, so its unknown start flushes out
        if (lk_tgl_ff[1] == lk_tgl_ff[2]) lk_seen_ff <= lk_tgl_ff[2];
        if (lk_tgl_ff[1] == lk_tgl_ff[2] && lk_tgl_ff[2] != lk_seen_ff) begin
            lk_sync_ff <= 1'b1; // R3
            lk_active_ff <= 1'b1;
            lk_shift_ff <= ext_word_ff;
            lk_data_ff <= ext_word_ff[WORD_BITS-1];
        end else begin
            lk_sync_ff <= 1'b0;
            // after the word the tag level follows, 16 bit clocks late; the host
            // keeps cs low and read-convert high while it reads that far
            if (lk_active_ff && !lk_sync_ff) begin
                lk_shift_ff <= {lk_shift_ff[WORD_BITS-2:0], tag_in}; // R12 R13
                lk_data_ff <= lk_shift_ff[WORD_BITS-2];
            end
        end
    end

    assign serial_bit_clock_out = int_clk_ff;
    assign serial_bit_clock_oe_out = !ext_ff;
    assign serial_data_out = ext_ff ? lk_data_ff : int_data_ff;
    assign sync_out = lk_sync_ff;
endmodule // scr_core

// ==== tb/scr_core_properties.sv ====
// Purpose: port checker for the converter control block
// Assumes: bound into scr_core, clk_in domain except the sync cover on link_clk_in
// Notes: counters stand in for long repetitions
`timescale 1ns/100ps
`include "scr_consts.svh"
module scr_core_properties #(
    parameter int WORD_BITS = 16,
    parameter int CONV_CYCLES = 1520
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic link_clk_in,
    input wire logic chip_select_n_in,
    input wire logic read_convert_in,
    input wire logic power_down_in,
    input wire logic clock_source_select_in,
    input wire logic result_ready_in,
    input wire logic busy_n_out,
    input wire logic power_reduced_out,
    input wire logic serial_bit_clock_out,
    input wire logic serial_bit_clock_oe_out,
    input wire logic sync_out,
    input wire logic result_valid_out,
    input wire logic [WORD_BITS-1:0] result_data_out
);
    localparam int HALF = `SCR_HALF_BIT_CYCLES;
    int low_cnt_ff;
    int hi_cnt_ff;
    // ==========
    // helper counters
    always_ff @(posedge clk_in) begin
        low_cnt_ff <= (rst_in || busy_n_out) ? 0 : low_cnt_ff + 1;
    end
    always_ff @(posedge clk_in) begin
        hi_cnt_ff <= (rst_in || !serial_bit_clock_out) ? 0 : hi_cnt_ff + 1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ==========
    // assertions
    AST_BUSY_LEN: assert property ($rose(busy_n_out) |-> low_cnt_ff == CONV_CYCLES)
        else $error("busy low time wrong");
    AST_START_CAUSE: assert property ($fell(busy_n_out) |->
        $past(!chip_select_n_in && !read_convert_in && !power_down_in))
        else $error("conversion started without trigger");
    AST_PD_NO_START: assert property (power_down_in[*5] ##0 busy_n_out |=> busy_n_out)
        else $error("conversion started in power down");
    AST_PD_FLAG: assert property (power_down_in[*5] |-> power_reduced_out)
        else $error("power down not entered");
    AST_HALF_BIT: assert property ($fell(serial_bit_clock_out) |-> hi_cnt_ff == HALF)
        else $error("bit clock high time wrong");
    AST_FIRST_RISE: assert property ($fell(busy_n_out) && !clock_source_select_in |->
        ##[80:100] $rose(serial_bit_clock_out))
        else $error("first bit clock late");
    AST_OE_INT: assert property (!clock_source_select_in[*5] |-> serial_bit_clock_oe_out)
        else $error("bit clock not driven");
    AST_VALID_HOLD: assert property (result_valid_out && !result_ready_in |=>
        result_valid_out && $stable(result_data_out))
        else $error("stalled word changed");
    COV_START: cover property ($fell(busy_n_out));
    COV_PD: cover property (power_reduced_out);
    COV_SYNC: cover property (@(posedge link_clk_in) sync_out);
endmodule // scr_core_properties

// ==== tb/scr_host_model.sv ====
// Purpose: host side of the serial link in external clock mode
// Assumes: one frame of 40 link clocks per go pulse
// Notes: link clock stands low outside frames
`timescale 1ns/100ps
module scr_host_model (
    input wire logic go_in,
    input wire logic sync_in,
    input wire logic data_in,
    output logic link_clk_out,
    output logic [17:0] word_out,
    output logic done_out
);
    int cnt;
    initial begin
        link_clk_out = 1'b0;
        word_out = 18'h00000;
        done_out = 1'b0;
        forever begin
            @(posedge go_in);
            done_out = 1'b0;
            // odd offset keeps link edges away from system edges
            #13;
            cnt = 0;
            repeat (40) begin
                #40 link_clk_out = 1'b1;
                #40 link_clk_out = 1'b0;
                if (sync_in === 1'b1) cnt = 1;
                else if (cnt > 0 && cnt < 19) begin
                    word_out = {word_out[16:0], data_in};
                    cnt++;
                end
            end
            done_out = 1'b1;
        end
    end
endmodule // scr_host_model

// ==== tb/sar_convert_and_serial_readout_tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: conversion shortened to 40 cycles
// Notes: the stream buffer is stalled over two conversions
`timescale 1ns/100ps
module sar_convert_and_serial_readout_tb;
    logic clk_in = 1'b0, rst_in = 1'b1, link_clk_in, chip_select_n_in = 1'b0;
    logic read_convert_in = 1'b1, power_down_in = 1'b0, clock_source_select_in = 1'b0;
    logic output_format_select_in = 1'b1, tag_in = 1'b1, result_ready_in = 1'b0;
    logic [15:0] sample_in = 16'h0000, result_data_out;
    logic busy_n_out, power_reduced_out, serial_bit_clock_out, serial_bit_clock_oe_out;
    logic serial_data_out, sync_out, result_valid_out, go = 1'b0, done;
    logic [17:0] word;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    always #2.5 clk_in = ~clk_in;
    scr_core #(.CONV_CYCLES(40)) dut_u (.*);
    scr_host_model host_u (.go_in(go), .sync_in(sync_out), .data_in(serial_data_out),
        .link_clk_out(link_clk_in), .word_out(word), .done_out(done));
    // ==========
    // shared tasks
    task automatic check(input string name, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // ==========
    // scenarios
    task automatic t_blocked(input logic cs, pd);
        logic low = 1'b0;
        @(negedge clk_in);
        chip_select_n_in = cs;
        power_down_in = pd;
        repeat (8) @(negedge clk_in);
        read_convert_in = 1'b0;
        repeat (60) begin
            @(negedge clk_in);
            low = low | (busy_n_out !== 1'b1);
        end
        check("power reduced", power_reduced_out, pd);
        check("no start", low, 1'b0);
        read_convert_in = 1'b1;
        @(negedge clk_in);
        chip_select_n_in = 1'b0;
        repeat (8) @(negedge clk_in);
        power_down_in = 1'b0;
    endtask
    task automatic t_internal(input logic [15:0] smp, exp, input logic chk);
        logic [15:0] w = 16'h0000;
        logic prev = 1'b0;
        int rises = 0;
        int first = 0;
        @(negedge clk_in);
        sample_in = smp;
        read_convert_in = 1'b0;
        for (int i = 0; i < 1700; i++) begin
            @(negedge clk_in);
            if (busy_n_out === 1'b0) read_convert_in = 1'b1;
            if (serial_bit_clock_out === 1'b1 && prev === 1'b0) begin
                w = {w[14:0], serial_data_out};
                rises++;
                if (rises == 1) first = i;
            end
            prev = serial_bit_clock_out;
        end
        check("pulses", 16'(rises), 16'h0010);
        check("first rise", 16'(first >= 80 && first <= 100), 16'h0001);
        if (chk) check("word", w, exp);
    endtask
    task automatic t_buffer(input logic [15:0] w0, w1);
        check("full", result_valid_out, 1'b1);
        check("word0", result_data_out, w0);
        result_ready_in = 1'b1;
        @(negedge clk_in);
        check("word1", result_data_out, w1);
        @(negedge clk_in);
        check("empty", result_valid_out, 1'b0);
    endtask
    task automatic t_external(input logic [15:0] smp, exp);
        @(negedge clk_in);
        clock_source_select_in = 1'b1;
        output_format_select_in = 1'b0;
        chip_select_n_in = 1'b1;
        sample_in = smp;
        repeat (8) @(negedge clk_in);
        read_convert_in = 1'b0;
        repeat (8) @(negedge clk_in);
        chip_select_n_in = 1'b0;
        for (int i = 0; i < 20 && busy_n_out !== 1'b0; i++) @(negedge clk_in);
        chip_select_n_in = 1'b1;
        repeat (60) @(negedge clk_in);
        read_convert_in = 1'b1;
        go = 1'b1;
        repeat (100) @(negedge clk_in);
        chip_select_n_in = 1'b0;
        for (int i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk_in);
        check("ext word", word[17:2], exp);
        check("tag", 16'(word[1:0]), 16'h0003);
    endtask
    task automatic t_ext_during(input logic [15:0] smp, exp);
        @(negedge clk_in);
        go = 1'b0;
        tag_in = 1'b0;
        sample_in = smp;
        @(negedge clk_in);
        go = 1'b1;
        repeat (100) @(negedge clk_in);
        read_convert_in = 1'b0;
        for (int i = 0; i < 20 && busy_n_out !== 1'b0; i++) @(negedge clk_in);
        read_convert_in = 1'b1;
        for (int i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk_in);
        check("busy ext", busy_n_out, 1'b1);
        check("during word", word[17:2], exp);
        check("tag low", 16'(word[1:0]), 16'h0000);
    endtask
    initial begin
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        t_blocked(1'b1, 1'b0);
        t_internal(16'h1234, 16'h0000, 1'b0);
        t_internal(16'hA5C3, 16'h9234, 1'b1);
        t_buffer(16'h9234, 16'h25C3);
        t_blocked(1'b0, 1'b1);
        t_internal(16'h0F0F, 16'h25C3, 1'b1);
        t_external(16'h8001, 16'h8001);
        t_ext_during(16'h7FFE, 16'h8001);
        finish_test();
    end
endmodule // sar_convert_and_serial_readout_tb
bind scr_core scr_core_properties #(.WORD_BITS(WORD_BITS), .CONV_CYCLES(CONV_CYCLES))
    chk_u (.*);
